//--- inc/spa_pkg.sv
// constants of the servo protection and alarm block
// How it works
// - encoder link silent too long trips 21
// - encoder frame data error trips 23
// - position deviation above limit trips 24
// - zero deviation limit disables error 24
// - full-closed scale/encoder slip trips 25
// - speed above overspeed limit trips 26
// - scale frame with data error trips 28
// - deviation above two to 27 trips 29
// - motor beyond travel range trips 34
// - zero travel range disables error 34
// - clear input ignores codes 21,23,25,28
package spa_pkg;

	// ------------------------------------------------------------
	// register map, byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_ALARM     = 8'h04;
	localparam logic [7:0] ADDR_POS_LIMIT = 8'h08;
	localparam logic [7:0] ADDR_HYB_LIMIT = 8'h0c;
	localparam logic [7:0] ADDR_SPD_LIMIT = 8'h10;
	localparam logic [7:0] ADDR_TRAVEL    = 8'h14;
	localparam logic [7:0] ADDR_IRQ_STAT  = 8'h18;
	localparam logic [7:0] ADDR_IRQ_MASK  = 8'h1c;
	localparam logic [7:0] ADDR_DEVIATION = 8'h20;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_SERVO_ON   = 0;
	localparam int CTRL_FULLCLOSED = 1;
	localparam int CTRL_CLEAR      = 2;
	localparam int ALARM_ACTIVE    = 8;
	localparam int ALARM_CLEARABLE = 9;
	localparam int IRQ_TRIP        = 0;
	localparam int IRQ_CLEARED     = 1;
	localparam int IRQ_BITS        = 2;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [2:0]  CTRL_RESET      = 3'h0;
	localparam logic [31:0] POS_LIMIT_RESET = 32'h0000_0000;
	localparam logic [31:0] HYB_LIMIT_RESET = 32'h0000_ffff;
	localparam logic [15:0] SPD_LIMIT_RESET = 16'hffff;
	localparam logic [31:0] TRAVEL_RESET    = 32'h0000_0000;

	// ------------------------------------------------------------
	// alarm codes
	// ------------------------------------------------------------
	localparam logic [7:0] CODE_NONE     = 8'h00;
	localparam logic [7:0] CODE_ENC_LOST = 8'h15; // 21
	localparam logic [7:0] CODE_ENC_DATA = 8'h17; // 23
	localparam logic [7:0] CODE_POS_DEV  = 8'h18; // 24
	localparam logic [7:0] CODE_HYBRID   = 8'h19; // 25
	localparam logic [7:0] CODE_SPEED    = 8'h1a; // 26
	localparam logic [7:0] CODE_SCL_DATA = 8'h1c; // 28
	localparam logic [7:0] CODE_DEV_OVF  = 8'h1d; // 29
	localparam logic [7:0] CODE_TRAVEL   = 8'h22; // 34

	// deviation counter overflow threshold, two to the 27th
	localparam logic [31:0] DEV_OVF_LIMIT = 32'h0800_0000;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS    = 40;
	localparam int ENC_LOSS_TIME_NS = 100000;
	localparam int ENC_LOSS_CYCLES  = (ENC_LOSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOSS_CNT_BITS    = 12;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- logic/spa_dev_cmp.sv
// magnitude of a position difference compared against a limit
`timescale 1ns/100ps
module spa_dev_cmp (
	input  wire logic        [31:0] pos_a,
	input  wire logic        [31:0] pos_b,
	input  wire logic        [31:0] limit,
	input  wire logic               check_en,
	output logic                    over,
	output logic             [31:0] diff
);
	// ------------------------------------------------------------
	// signed difference, widened so that it cannot wrap
	// ------------------------------------------------------------
	logic signed [32:0] delta;
	logic        [32:0] magnitude;

	assign delta     = $signed({pos_a[31], pos_a}) - $signed({pos_b[31], pos_b});
	assign magnitude = delta[32] ? 33'(-delta) : 33'(delta);
	assign diff      = delta[31:0];
	assign over      = check_en && (magnitude > {1'b0, limit});

endmodule

//--- logic/spa_link_watchdog.sv
// silence detector for a serial sensor link
`timescale 1ns/100ps
module spa_link_watchdog (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic frame_ok,
	output logic      lost
);
	// ------------------------------------------------------------
	// count cycles since the last good frame, saturate at limit
	// ------------------------------------------------------------
	localparam logic [spa_pkg::LOSS_CNT_BITS-1:0] LIMIT =
		spa_pkg::LOSS_CNT_BITS'(spa_pkg::ENC_LOSS_CYCLES);

	logic [spa_pkg::LOSS_CNT_BITS-1:0] silent;
	logic [spa_pkg::LOSS_CNT_BITS-1:0] next_silent;

	assign next_silent = frame_ok ? '0 :
		(silent == LIMIT) ? silent : silent + 1'b1;
	assign lost        = (silent == LIMIT);

	// silence counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			silent <= '0;
		end else begin
			silent <= next_silent;
		end
	end

endmodule

//--- logic/spa_protect.sv
// servo protection and alarm logic with an axi4-lite register slave
`timescale 1ns/100ps
module spa_protect (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// encoder link
	input  wire logic        enc_frame_valid,
	input  wire logic        enc_frame_error,
	input  wire logic [31:0] enc_position,
	// external scale link
	input  wire logic        scale_frame_valid,
	input  wire logic        scale_data_error,
	input  wire logic [31:0] scale_position,
	// command and speed
	input  wire logic [31:0] cmd_position,
	input  wire logic [15:0] motor_speed,
	// alarm clear pin and outputs
	input  wire logic        alarm_clear,
	output logic             drive_enable,
	output logic             alarm_active,
	output logic [7:0]       alarm_code,
	output logic             irq
);

	// ------------------------------------------------------------
	// configuration and status registers
	// ------------------------------------------------------------
	logic                         servo_on;
	logic                         full_closed;
	logic [31:0]                  position_deviation_limit;
	logic [31:0]                  hybrid_deviation_limit;
	logic [15:0]                  overspeed_limit;
	logic [31:0]                  soft_travel_range;
	logic [spa_pkg::IRQ_BITS-1:0] irq_status;
	logic [spa_pkg::IRQ_BITS-1:0] irq_mask;

	// ------------------------------------------------------------
	// axi write channel state
	// ------------------------------------------------------------
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        wr_fire;
	logic [31:0] wr_mask;

	// address and data are latched independently, either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

	// expand byte strobes to a bit mask
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane++) begin : g_lane
			assign wr_mask[lane*8 +: 8] = {8{w_strb[lane]}};
		end
	endgenerate

	// write address/data holding registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// write decode
	// ------------------------------------------------------------
	wire wr_ctrl   = wr_fire && (aw_addr == spa_pkg::ADDR_CTRL);
	wire wr_pos    = wr_fire && (aw_addr == spa_pkg::ADDR_POS_LIMIT);
	wire wr_hyb    = wr_fire && (aw_addr == spa_pkg::ADDR_HYB_LIMIT);
	wire wr_spd    = wr_fire && (aw_addr == spa_pkg::ADDR_SPD_LIMIT);
	wire wr_travel = wr_fire && (aw_addr == spa_pkg::ADDR_TRAVEL);
	wire wr_mask_r = wr_fire && (aw_addr == spa_pkg::ADDR_IRQ_MASK);
	wire wr_ro     = wr_fire && ((aw_addr == spa_pkg::ADDR_ALARM)
		|| (aw_addr == spa_pkg::ADDR_IRQ_STAT)
		|| (aw_addr == spa_pkg::ADDR_DEVIATION));
	wire wr_known  = wr_ctrl || wr_pos || wr_hyb || wr_spd || wr_travel
		|| wr_mask_r || wr_ro;

	// software clear pulse from the control register
	wire sw_clear  = wr_ctrl && w_strb[0] && w_data[spa_pkg::CTRL_CLEAR];

	// merged values under byte strobes
	wire [31:0] ctrl_now   = {29'h0, sw_clear, full_closed, servo_on};
	wire [31:0] ctrl_new   = (ctrl_now & ~wr_mask) | (w_data & wr_mask);
	wire [31:0] pos_new    = (position_deviation_limit & ~wr_mask) | (w_data & wr_mask);
	wire [31:0] hyb_new    = (hybrid_deviation_limit & ~wr_mask) | (w_data & wr_mask);
	wire [31:0] spd_new    = ({16'h0, overspeed_limit} & ~wr_mask) | (w_data & wr_mask);
	wire [31:0] travel_new = (soft_travel_range & ~wr_mask) | (w_data & wr_mask);

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= spa_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_known ? spa_pkg::RESP_OKAY : spa_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// writable configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			servo_on                 <= spa_pkg::CTRL_RESET[spa_pkg::CTRL_SERVO_ON];
			full_closed              <= spa_pkg::CTRL_RESET[spa_pkg::CTRL_FULLCLOSED];
			position_deviation_limit <= spa_pkg::POS_LIMIT_RESET;
			hybrid_deviation_limit   <= spa_pkg::HYB_LIMIT_RESET;
			overspeed_limit          <= spa_pkg::SPD_LIMIT_RESET;
			soft_travel_range        <= spa_pkg::TRAVEL_RESET;
			irq_mask                 <= '0;
		end else begin
			if (wr_ctrl) begin
				servo_on    <= ctrl_new[spa_pkg::CTRL_SERVO_ON];
				full_closed <= ctrl_new[spa_pkg::CTRL_FULLCLOSED];
			end
			if (wr_pos)
				position_deviation_limit <= pos_new;
			if (wr_hyb)
				hybrid_deviation_limit <= hyb_new;
			if (wr_spd)
				overspeed_limit <= spd_new[15:0];
			if (wr_travel)
				soft_travel_range <= travel_new;
			if (wr_mask_r)
				irq_mask <= w_data[spa_pkg::IRQ_BITS-1:0];
		end
	end

	// ------------------------------------------------------------
	// protection checks
	// ------------------------------------------------------------
	logic [31:0] deviation;
	logic        enc_lost;
	logic        pos_dev_over;
	logic        dev_ovf_over;
	logic        hybrid_over;

	// encoder silence detector
	spa_link_watchdog u_enc_watch (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.frame_ok (enc_frame_valid && !enc_frame_error),
		.lost     (enc_lost)
	);

	// command versus encoder, against the user limit
	spa_dev_cmp u_pos_dev (
		.pos_a    (cmd_position),
		.pos_b    (enc_position),
		.limit    (position_deviation_limit),
		.check_en (servo_on && (position_deviation_limit != 32'h0000_0000)),
		.over     (pos_dev_over),
		.diff     (deviation)
	);

	// command versus encoder, against the counter capacity
	spa_dev_cmp u_dev_ovf (
		.pos_a    (cmd_position),
		.pos_b    (enc_position),
		.limit    (spa_pkg::DEV_OVF_LIMIT),
		.check_en (servo_on),
		.over     (dev_ovf_over),
		.diff     ()
	);

	// scale versus encoder under full-closed control
	spa_dev_cmp u_hybrid (
		.pos_a    (scale_position),
		.pos_b    (enc_position),
		.limit    (hybrid_deviation_limit),
		.check_en (servo_on && full_closed),
		.over     (hybrid_over),
		.diff     ()
	);

	// speed magnitude against the overspeed limit
	wire [15:0] speed_mag  = motor_speed[15] ? 16'(-motor_speed) : motor_speed;
	wire        speed_over = servo_on && (speed_mag > overspeed_limit);

	// travel window tracked from the command range
	logic signed [33:0] cmd_low;
	logic signed [33:0] cmd_high;
	logic               alarm_clear_ok;
	wire  signed [33:0] cmd_s    = 34'($signed(cmd_position));
	wire  signed [33:0] enc_s    = 34'($signed(enc_position));
	wire  signed [33:0] range_s  = $signed({2'b00, soft_travel_range});
	wire                track_rst = !servo_on || alarm_clear_ok;
	wire                travel_over = servo_on && (soft_travel_range != 32'h0000_0000)
		&& ((enc_s > cmd_high + range_s) || (enc_s < cmd_low - range_s));

	// command range, restarted while servo is off or on a clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_low  <= '0;
			cmd_high <= '0;
		end else if (track_rst) begin
			cmd_low  <= cmd_s;
			cmd_high <= cmd_s;
		end else begin
			if (cmd_s < cmd_low)
				cmd_low <= cmd_s;
			if (cmd_s > cmd_high)
				cmd_high <= cmd_s;
		end
	end

	// ------------------------------------------------------------
	// trip selection, lowest code wins on a tie
	// ------------------------------------------------------------
	logic [7:0] trip_code;
	logic       trip_now;

	always_comb begin
		trip_now  = 1'b1;
		if (enc_lost)
			trip_code = spa_pkg::CODE_ENC_LOST;
		else if (enc_frame_valid && enc_frame_error)
			trip_code = spa_pkg::CODE_ENC_DATA;
		else if (pos_dev_over)
			trip_code = spa_pkg::CODE_POS_DEV;
		else if (hybrid_over)
			trip_code = spa_pkg::CODE_HYBRID;
		else if (speed_over)
			trip_code = spa_pkg::CODE_SPEED;
		else if (scale_frame_valid && scale_data_error)
			trip_code = spa_pkg::CODE_SCL_DATA;
		else if (dev_ovf_over)
			trip_code = spa_pkg::CODE_DEV_OVF;
		else if (travel_over)
			trip_code = spa_pkg::CODE_TRAVEL;
		else begin
			trip_code = spa_pkg::CODE_NONE;
			trip_now  = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// alarm latch and clearing
	// ------------------------------------------------------------
	logic alarm_clear_d;
	logic clear_req;
	logic clearable;

	// starred codes stay latched until reset
	assign clearable = (alarm_code != spa_pkg::CODE_ENC_LOST)
		&& (alarm_code != spa_pkg::CODE_ENC_DATA)
		&& (alarm_code != spa_pkg::CODE_HYBRID)
		&& (alarm_code != spa_pkg::CODE_SCL_DATA);
	assign clear_req      = (alarm_clear && !alarm_clear_d) || sw_clear;
	assign alarm_clear_ok = alarm_active && clear_req && clearable;

	// clear pin edge reference
	always_ff @(posedge aclk) begin
		if (!aresetn)
			alarm_clear_d <= 1'b0;
		else
			alarm_clear_d <= alarm_clear;
	end

	// first trip holds its code until cleared
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alarm_active <= 1'b0;
			alarm_code   <= spa_pkg::CODE_NONE;
		end else if (!alarm_active && trip_now) begin
			alarm_active <= 1'b1;
			alarm_code   <= trip_code;
		end else if (alarm_clear_ok) begin
			alarm_active <= 1'b0;
			alarm_code   <= spa_pkg::CODE_NONE;
		end
	end

	// drive stays off while an alarm is held
	always_ff @(posedge aclk) begin
		if (!aresetn)
			drive_enable <= 1'b0;
		else
			drive_enable <= servo_on && !alarm_active && !trip_now;
	end

	// ------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------
	wire        rd_fire  = s_axi_arvalid && s_axi_arready;
	wire        rd_istat = rd_fire && (s_axi_araddr == spa_pkg::ADDR_IRQ_STAT);
	logic [31:0] rd_value;
	logic        rd_known;

	assign s_axi_arready = !s_axi_rvalid;

	// read multiplexer
	always_comb begin
		rd_known = 1'b1;
		unique case (s_axi_araddr)
			spa_pkg::ADDR_CTRL:      rd_value = {30'h0, full_closed, servo_on};
			spa_pkg::ADDR_ALARM:     rd_value = {22'h0, clearable && alarm_active,
				alarm_active, alarm_code};
			spa_pkg::ADDR_POS_LIMIT: rd_value = position_deviation_limit;
			spa_pkg::ADDR_HYB_LIMIT: rd_value = hybrid_deviation_limit;
			spa_pkg::ADDR_SPD_LIMIT: rd_value = {16'h0, overspeed_limit};
			spa_pkg::ADDR_TRAVEL:    rd_value = soft_travel_range;
			spa_pkg::ADDR_IRQ_STAT:  rd_value = {30'h0, irq_status};
			spa_pkg::ADDR_IRQ_MASK:  rd_value = {30'h0, irq_mask};
			spa_pkg::ADDR_DEVIATION: rd_value = deviation;
			default: begin
				rd_value = 32'h0000_0000;
				rd_known = 1'b0;
			end
		endcase
	end

	// read data register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= spa_pkg::RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_value;
			s_axi_rresp  <= rd_known ? spa_pkg::RESP_OKAY : spa_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// interrupt status, read clears, new events win
	// ------------------------------------------------------------
	wire [spa_pkg::IRQ_BITS-1:0] irq_event = {alarm_clear_ok, !alarm_active && trip_now};

	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq_status <= '0;
		else
			irq_status <= (rd_istat ? '0 : irq_status) | irq_event;
	end

	assign irq = |(irq_status & irq_mask);

endmodule

//--- test/spa_sensor_model.sv
// encoder and external scale link model with frame and error injection
`timescale 1ns/100ps
module spa_sensor_model (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic link_on,
	input  wire logic enc_bad,
	input  wire logic scale_bad,
	output logic      enc_frame_valid,
	output logic      enc_frame_error,
	output logic      scale_frame_valid,
	output logic      scale_data_error
);
	logic [3:0] slot;

	// frame slot counter, one encoder and one scale frame every 16 cycles
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slot <= 4'h0;
		end else begin
			slot <= slot + 4'h1;
		end
	end

	// frames only while the link runs, so silence starves the watchdog
	assign enc_frame_valid = link_on && (slot == 4'h0);
	assign scale_frame_valid = link_on && (slot == 4'h8);
	// error flags carry noise outside frames
	assign enc_frame_error = enc_frame_valid ? enc_bad : slot[0];
	assign scale_data_error = scale_frame_valid ? scale_bad : slot[1];
endmodule

//--- test/spa_protect_assertions.sv
// port-level checks of the protection and alarm block
`timescale 1ns/100ps
module spa_protect_assertions (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        enc_frame_valid,
	input wire logic        enc_frame_error,
	input wire logic        scale_frame_valid,
	input wire logic        scale_data_error,
	input wire logic [31:0] enc_position,
	input wire logic [31:0] cmd_position,
	input wire logic        drive_enable,
	input wire logic        alarm_active,
	input wire logic [7:0]  alarm_code
);
	logic [31:0] dev;
	logic [31:0] dev_mag;
	logic        sticky;
	logic        enc_code;

	// deviation magnitude and code classes
	assign dev = cmd_position - enc_position;
	assign dev_mag = dev[31] ? 32'h0 - dev : dev;
	assign sticky = alarm_code inside {spa_pkg::CODE_ENC_LOST, spa_pkg::CODE_ENC_DATA,
		spa_pkg::CODE_HYBRID, spa_pkg::CODE_SCL_DATA};
	assign enc_code = alarm_code inside {spa_pkg::CODE_ENC_LOST, spa_pkg::CODE_ENC_DATA};

	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	drive_off_a: assert property (alarm_active |-> !drive_enable)
		else $error("drive enabled during alarm");
	code_hold_a: assert property (alarm_active && $past(alarm_active) |-> $stable(alarm_code))
		else $error("alarm code changed while held");
	sticky_code_a: assert property (alarm_active && sticky |=> alarm_active)
		else $error("uncleared code was released");
	enc_data_a: assert property (enc_frame_valid && enc_frame_error && !alarm_active |=> alarm_active && enc_code)
		else $error("bad encoder frame did not trip");
	scale_data_a: assert property (scale_frame_valid && scale_data_error && !alarm_active |=> alarm_active)
		else $error("bad scale frame did not trip");
	dev_ovf_a: assert property (drive_enable && !alarm_active && dev_mag > spa_pkg::DEV_OVF_LIMIT |=> alarm_active)
		else $error("deviation overflow did not trip");
	bresp_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken during read data");
endmodule

bind spa_protect spa_protect_assertions u_chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arready, .s_axi_rvalid, .enc_frame_valid, .enc_frame_error, .scale_frame_valid,
	.scale_data_error, .enc_position, .cmd_position, .drive_enable, .alarm_active, .alarm_code);

//--- test/test_spa_protect.sv
// self-checking bench for the servo protection and alarm block
`timescale 1ns/100ps
module test_spa_protect;
	logic        aclk, aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, alarm_code;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        enc_frame_valid, enc_frame_error, scale_frame_valid, scale_data_error;
	logic [31:0] enc_position = 32'h0, scale_position = 32'h0, cmd_position = 32'h0;
	logic [15:0] motor_speed = 16'h0;
	logic        alarm_clear = 1'b0, drive_enable, alarm_active, irq;
	logic        link_on = 1'b1, enc_bad = 1'b0, scale_bad = 1'b0;
	int          n_errors = 0, n_compared = 0, cycles = 0;

	spa_protect DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .enc_frame_valid, .enc_frame_error, .enc_position, .scale_frame_valid,
		.scale_data_error, .scale_position, .cmd_position, .motor_speed, .alarm_clear,
		.drive_enable, .alarm_active, .alarm_code, .irq);
	spa_sensor_model u_sensor (.aclk, .aresetn, .link_on, .enc_bad, .scale_bad, .enc_frame_valid,
		.enc_frame_error, .scale_frame_valid, .scale_data_error);

	// 25 MHz clock
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// hang guard
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			n_errors++;
			summarize();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic summarize();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// write, ready sampled just before each edge, released right after it
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
		logic ah, wh, ad, wd;
		logic [1:0] r;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		ad = 1'b0;
		wd = 1'b0;
		while (!(ad && wd)) begin
			@(negedge aclk);
			ah = s_axi_awvalid && s_axi_awready;
			wh = s_axi_wvalid && s_axi_wready;
			@(posedge aclk);
			if (ah) s_axi_awvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
			ad = ad || ah;
			wd = wd || wh;
		end
		ah = 1'b0;
		while (!ah) begin
			@(negedge aclk);
			ah = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
		end
		check("write resp", {30'h0, r}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
		logic hit;
		logic [31:0] d;
		logic [1:0] r;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		hit = 1'b0;
		while (!hit) begin
			@(negedge aclk);
			hit = s_axi_arready;
			@(posedge aclk);
		end
		s_axi_arvalid <= 1'b0;
		hit = 1'b0;
		while (!hit) begin
			@(negedge aclk);
			hit = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
		end
		check("read data", d, exp);
		check("read resp", {30'h0, r}, {30'h0, er});
	endtask

	// alarm outputs looked at mid-cycle
	task automatic alarm_is(input logic act, input logic [7:0] code, input logic drv, input logic iq);
		@(negedge aclk);
		check("alarm active", {31'h0, alarm_active}, {31'h0, act});
		check("alarm code", {24'h0, alarm_code}, {24'h0, code});
		check("drive enable", {31'h0, drive_enable}, {31'h0, drv});
		check("irq", {31'h0, irq}, {31'h0, iq});
		@(posedge aclk);
	endtask

	task automatic clr_pin();
		alarm_clear <= 1'b1;
		step(2);
		alarm_clear <= 1'b0;
		step(3);
	endtask

	task automatic do_reset();
		aresetn <= 1'b0;
		step(10);
		aresetn <= 1'b1;
		step(1);
	endtask

	// main sequence
	initial begin
		do_reset();
		rd(spa_pkg::ADDR_CTRL, 32'h0);
		rd(spa_pkg::ADDR_HYB_LIMIT, 32'hffff);
		rd(spa_pkg::ADDR_SPD_LIMIT, 32'hffff);
		rd(spa_pkg::ADDR_IRQ_MASK, 32'h0);
		rd(8'h24, 32'h0, spa_pkg::RESP_SLVERR);
		wr(8'h24, 32'h1, spa_pkg::RESP_SLVERR);
		wr(spa_pkg::ADDR_IRQ_MASK, 32'h3);
		wr(spa_pkg::ADDR_POS_LIMIT, 32'd100);
		wr(spa_pkg::ADDR_CTRL, 32'h1);
		cmd_position <= 32'd100;
		step(3);
		alarm_is(1'b0, 8'h00, 1'b1, 1'b0);
		cmd_position <= 32'd101;
		step(3);
		alarm_is(1'b1, spa_pkg::CODE_POS_DEV, 1'b0, 1'b1);
		rd(spa_pkg::ADDR_DEVIATION, 32'd101);
		cmd_position <= 32'h0;
		rd(spa_pkg::ADDR_ALARM, 32'h318);
		rd(spa_pkg::ADDR_IRQ_STAT, 32'h1);
		rd(spa_pkg::ADDR_IRQ_STAT, 32'h0);
		clr_pin();
		alarm_is(1'b0, 8'h00, 1'b1, 1'b1);
		rd(spa_pkg::ADDR_IRQ_STAT, 32'h2);
		wr(spa_pkg::ADDR_POS_LIMIT, 32'h0);
		cmd_position <= spa_pkg::DEV_OVF_LIMIT;
		step(3);
		alarm_is(1'b0, 8'h00, 1'b1, 1'b0);
		cmd_position <= spa_pkg::DEV_OVF_LIMIT + 32'h1;
		step(3);
		alarm_is(1'b1, spa_pkg::CODE_DEV_OVF, 1'b0, 1'b1);
		cmd_position <= 32'h0;
		wr(spa_pkg::ADDR_CTRL, 32'h5);
		wr(spa_pkg::ADDR_IRQ_MASK, 32'h0);
		wr(spa_pkg::ADDR_SPD_LIMIT, 32'd50);
		motor_speed <= 16'd50;
		step(3);
		alarm_is(1'b0, 8'h00, 1'b1, 1'b0);
		motor_speed <= 16'hffcd;
		step(3);
		alarm_is(1'b1, spa_pkg::CODE_SPEED, 1'b0, 1'b0);
		motor_speed <= 16'h0;
		clr_pin();
		rd(spa_pkg::ADDR_IRQ_STAT, 32'h3);
		enc_position <= 32'd5000;
		step(3);
		alarm_is(1'b0, 8'h00, 1'b1, 1'b0);
		enc_position <= 32'd10;
		wr(spa_pkg::ADDR_TRAVEL, 32'd10);
		step(3);
		alarm_is(1'b0, 8'h00, 1'b1, 1'b0);
		enc_position <= 32'hffff_fff5;
		step(3);
		alarm_is(1'b1, spa_pkg::CODE_TRAVEL, 1'b0, 1'b0);
		enc_position <= 32'h0;
		clr_pin();
		wr(spa_pkg::ADDR_HYB_LIMIT, 32'd10);
		scale_position <= 32'd10;
		wr(spa_pkg::ADDR_CTRL, 32'h3);
		step(3);
		alarm_is(1'b0, 8'h00, 1'b1, 1'b0);
		scale_position <= 32'd11;
		step(3);
		alarm_is(1'b1, spa_pkg::CODE_HYBRID, 1'b0, 1'b0);
		clr_pin();
		wr(spa_pkg::ADDR_CTRL, 32'h7);
		step(3);
		alarm_is(1'b1, spa_pkg::CODE_HYBRID, 1'b0, 1'b0);
		do_reset();
		enc_bad <= 1'b1;
		step(20);
		enc_bad <= 1'b0;
		clr_pin();
		alarm_is(1'b1, spa_pkg::CODE_ENC_DATA, 1'b0, 1'b0);
		do_reset();
		scale_bad <= 1'b1;
		step(20);
		scale_bad <= 1'b0;
		clr_pin();
		alarm_is(1'b1, spa_pkg::CODE_SCL_DATA, 1'b0, 1'b0);
		link_on <= 1'b0;
		do_reset();
		step(2400);
		alarm_is(1'b0, 8'h00, 1'b0, 1'b0);
		step(200);
		link_on <= 1'b1;
		clr_pin();
		alarm_is(1'b1, spa_pkg::CODE_ENC_LOST, 1'b0, 1'b0);
		summarize();
	end
endmodule
